// file: logic/mac_alu_defines.svh
// constants for the fractional mac data alu
`ifndef MAC_ALU_DEFINES_SVH
`define MAC_ALU_DEFINES_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define ALU_WORD_W        24
`define ALU_EXT_W         8
`define ALU_PAIR_W        48
`define ALU_ACC_W         56
`define ALU_SHAMT_W       6

// ---------------------------------------------------------------
// input register indices
// ---------------------------------------------------------------
`define IDX_X_HIGH        2'h0
`define IDX_X_LOW         2'h1
`define IDX_Y_HIGH        2'h2
`define IDX_Y_LOW         2'h3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define WORD_RESET        24'h000000
`define ACC_RESET         56'h00_000000_000000

// ---------------------------------------------------------------
// limiter and rounding constants
// ---------------------------------------------------------------
`define SAT_WORD_POS      24'h7fffff
`define SAT_WORD_NEG      24'h800000
`define SAT_PAIR_POS      48'h7fffff_ffffff
`define SAT_PAIR_NEG      48'h800000_000000
`define SAT16_WORD_POS    24'h7fff00
`define SAT16_PAIR_POS    48'h7fff00_ffff00
`define WORD16_MASK       24'hffff00
`define ACC16_MASK        56'hff_ffff00_ffff00
`define ROUND_CONST       56'h00_000000_800000
`define ROUND_MASK        56'hff_ffffff_000000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ALU_PIPE_CYCLES   2

`endif

// file: logic/mac_alu_pkg.sv
// types shared by the fractional mac data alu
package mac_alu_pkg;

  // ---------------------------------------------------------------
  // operations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    op_mpy, op_mac, op_add, op_sub, op_tfr, op_and, op_or, op_eor,
    op_asl, op_asr, op_lsr, op_clr, op_neg, op_rnd
  } alu_op_t;

  // adder source operand
  typedef enum logic [2:0] {
    src_x_high, src_x_low, src_y_high, src_y_low, src_x, src_y, src_other_acc
  } alu_src_t;

  // register selected by a bus transfer
  typedef enum logic [3:0] {
    rs_x_high, rs_x_low, rs_y_high, rs_y_low,
    rs_a_ext, rs_a_high, rs_a_low, rs_b_ext, rs_b_high, rs_b_low,
    rs_a, rs_b, rs_x, rs_y
  } reg_sel_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    alu_op_t     op;
    logic [1:0]  mul_a;
    logic [1:0]  mul_b;
    logic        signed_a;
    logic        signed_b;
    alu_src_t    src;
    logic        dst_b;
    logic        round;
    logic        cond_en;
    logic [5:0]  shift_amt;
  } alu_cmd_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        wide;
    reg_sel_t    sel;
    logic [47:0] wdata;
  } bus_req_t;

endpackage

// file: logic/bus_limiter.sv
// shifter/limiter on one data bus read path
`timescale 1ns/1ns
`include "mac_alu_defines.svh"

module bus_limiter (
  input  wire logic [55:0] acc_value,
  input  wire logic        wide,
  input  wire logic        mode16,
  output logic      [47:0] limited_data,
  output logic             limited
);

  logic overflow;
  logic neg;

  // value fits only when ext and bit 47 agree
  assign overflow = !((&acc_value[55:47]) || !(|acc_value[55:47]));
  assign neg      = acc_value[55];

  // ---------------------------------------------------------------
  // saturation
  // ---------------------------------------------------------------
  always_comb begin
    limited = overflow;
    if (wide) begin
      limited_data = acc_value[47:0];
      if (overflow) begin
        limited_data = neg ? `SAT_PAIR_NEG : (mode16 ? `SAT16_PAIR_POS : `SAT_PAIR_POS);
      end
      if (mode16) begin
        limited_data = limited_data & {`WORD16_MASK, `WORD16_MASK};
      end
    end else begin
      limited_data = {24'h000000, acc_value[47:24]};
      if (overflow) begin
        limited_data = {24'h000000,
                        neg ? `SAT_WORD_NEG : (mode16 ? `SAT16_WORD_POS : `SAT_WORD_POS)};
      end
      if (mode16) begin
        limited_data = limited_data & {24'h000000, `WORD16_MASK};
      end
    end
  end

endmodule // bus_limiter

// file: logic/fractional_mac_data_alu.sv
// two-stage fractional mac data alu with accumulators and bus paths
// Overview of operation
// - four 24-bit input registers feed the multiplier and adder.
// - two 56-bit accumulators, each ext, high and low parts.
// - registers load and read over both buses, 24/48 or 16/32 bits.
// - arithmetic operands come only from datapath registers, width per mode.
// - every operation result goes into accumulator a or b.
// - two-stage pipeline accepts one new operation every clock.
// - next operation reads the just written accumulator without stall.
// - mac takes up to three operands, gives one 56-bit result.
// - 24x24 multiply with signed, unsigned or mixed operands.
// - 48-bit product right-justified, added to full 56-bit accumulator.
// - a 56-bit accumulator can be stored as one 24-bit word.
// - round lower field into upper when asked, else keep the lower field.
// - a mode input selects 24-bit or 16-bit arithmetic.
// - 56-bit barrel shifter performs arithmetic and logical shifts.
// - one shifter/limiter sits on each data bus read path.
// - conditional operations execute only when the condition holds.
`timescale 1ns/1ns
`include "mac_alu_defines.svh"

module fractional_mac_data_alu #(
  parameter int WORD_W     = `ALU_WORD_W,
  parameter int ACC_W      = `ALU_ACC_W,
  parameter int PIPE_STAGES = `ALU_PIPE_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 sixteen_bit_mode,
  input  wire mac_alu_pkg::alu_cmd_t cmd,
  input  wire logic                 cond_true,
  input  wire mac_alu_pkg::bus_req_t first_memory_data_bus,
  input  wire mac_alu_pkg::bus_req_t second_memory_data_bus,
  output logic               [47:0] first_bus_rdata,
  output logic                      first_bus_limited,
  output logic               [47:0] second_bus_rdata,
  output logic                      second_bus_limited,
  output logic                      result_valid,
  output logic                      result_zero,
  output logic                      result_negative,
  output logic               [55:0] acc_a,
  output logic               [55:0] acc_b
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (WORD_W != `ALU_WORD_W || ACC_W != `ALU_ACC_W || PIPE_STAGES != `ALU_PIPE_CYCLES) begin
    $error("datapath widths and depth are fixed at 24/56/2");
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [23:0] in_reg_ff [4];
  logic [55:0] acc_a_ff, acc_b_ff;

  logic [7:0]  acc_a_ext, acc_b_ext;
  logic [23:0] acc_a_high, acc_a_low, acc_b_high, acc_b_low;
  logic [23:0] operand_x_high, operand_x_low, operand_y_high, operand_y_low;

  assign acc_a_ext  = acc_a_ff[55:48];
  assign acc_a_high = acc_a_ff[47:24];
  assign acc_a_low  = acc_a_ff[23:0];
  assign acc_b_ext  = acc_b_ff[55:48];
  assign acc_b_high = acc_b_ff[47:24];
  assign acc_b_low  = acc_b_ff[23:0];
  assign operand_x_high = in_reg_ff[`IDX_X_HIGH];
  assign operand_x_low  = in_reg_ff[`IDX_X_LOW];
  assign operand_y_high = in_reg_ff[`IDX_Y_HIGH];
  assign operand_y_low  = in_reg_ff[`IDX_Y_LOW];
  assign acc_a = acc_a_ff;
  assign acc_b = acc_b_ff;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // narrow a bus word in 16-bit mode
  function automatic logic [23:0] f_word(input logic [23:0] w, input logic m16);
    f_word = m16 ? (w & `WORD16_MASK) : w;
  endfunction

  function automatic logic [55:0] f_mul(input logic [23:0] a, input logic [23:0] b,
                                        input logic sa, input logic sb);
    logic signed [24:0] ea, eb;
    logic signed [49:0] p;
    ea = {sa & a[23], a};
    eb = {sb & b[23], b};
    p  = ea * eb;
    f_mul = {{5{p[49]}}, p[49:0], 1'b0};
  endfunction

  function automatic logic [55:0] f_shift(input logic [55:0] v, input mac_alu_pkg::alu_op_t op,
                                          input logic [5:0] amt);
    logic [5:0] n;
    n = (amt > 6'h37) ? 6'h37 : amt;
    unique case (op)
      mac_alu_pkg::op_asl: f_shift = v << n;
      mac_alu_pkg::op_asr: f_shift = $unsigned($signed(v) >>> n);
      default:             f_shift = v >> n;
    endcase
  endfunction

  // apply one bus write to an accumulator
  function automatic logic [55:0] f_acc_load(input logic [55:0] cur,
                                             input mac_alu_pkg::bus_req_t r,
                                             input logic m16, input logic is_b);
    logic [55:0] v;
    logic [23:0] hi, lo;
    v  = cur;
    hi = f_word(r.wdata[47:24], m16);
    lo = f_word(r.wdata[23:0], m16);
    unique case (r.sel)
      mac_alu_pkg::rs_a_ext, mac_alu_pkg::rs_b_ext: v[55:48] = r.wdata[7:0];
      mac_alu_pkg::rs_a_high, mac_alu_pkg::rs_b_high: v[47:24] = f_word(r.wdata[23:0], m16);
      mac_alu_pkg::rs_a_low, mac_alu_pkg::rs_b_low: v[23:0] = f_word(r.wdata[23:0], m16);
      mac_alu_pkg::rs_a, mac_alu_pkg::rs_b:
        v = r.wide ? {{8{hi[23]}}, hi, lo} : {{8{lo[23]}}, lo, 24'h000000};
      default: v = cur;
    endcase
    f_acc_load = v;
  endfunction

  // true when a bus request writes the given accumulator
  function automatic logic f_hits_acc(input mac_alu_pkg::bus_req_t r, input logic is_b);
    unique case (r.sel)
      mac_alu_pkg::rs_a_ext, mac_alu_pkg::rs_a_high, mac_alu_pkg::rs_a_low, mac_alu_pkg::rs_a:
        f_hits_acc = r.wr && !is_b;
      mac_alu_pkg::rs_b_ext, mac_alu_pkg::rs_b_high, mac_alu_pkg::rs_b_low, mac_alu_pkg::rs_b:
        f_hits_acc = r.wr && is_b;
      default:
        f_hits_acc = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // input registers
  // ---------------------------------------------------------------
  // four operand registers
  // bus loads, second bus wins a clash
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        in_reg_ff[i] <= `WORD_RESET;
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        mac_alu_pkg::bus_req_t r;
        r = (k == 0) ? first_memory_data_bus : second_memory_data_bus;
        if (r.wr) begin
          unique case (r.sel)
            mac_alu_pkg::rs_x_high: in_reg_ff[`IDX_X_HIGH] <= f_word(r.wdata[23:0], sixteen_bit_mode);
            mac_alu_pkg::rs_x_low:  in_reg_ff[`IDX_X_LOW]  <= f_word(r.wdata[23:0], sixteen_bit_mode);
            mac_alu_pkg::rs_y_high: in_reg_ff[`IDX_Y_HIGH] <= f_word(r.wdata[23:0], sixteen_bit_mode);
            mac_alu_pkg::rs_y_low:  in_reg_ff[`IDX_Y_LOW]  <= f_word(r.wdata[23:0], sixteen_bit_mode);
            mac_alu_pkg::rs_x: begin
              in_reg_ff[`IDX_X_HIGH] <= f_word(r.wdata[47:24], sixteen_bit_mode);
              in_reg_ff[`IDX_X_LOW]  <= f_word(r.wdata[23:0], sixteen_bit_mode);
            end
            mac_alu_pkg::rs_y: begin
              in_reg_ff[`IDX_Y_HIGH] <= f_word(r.wdata[47:24], sixteen_bit_mode);
              in_reg_ff[`IDX_Y_LOW]  <= f_word(r.wdata[23:0], sixteen_bit_mode);
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // stage 1: issue, multiply, operand fetch
  // ---------------------------------------------------------------
  logic                   s1_valid_ff, issue_exec;
  mac_alu_pkg::alu_cmd_t  s1_cmd_ff;
  logic [55:0]            s1_prod_ff, s1_opnd_ff, nxt_opnd;

  // drop a conditional op whose condition is false
  assign issue_exec = cmd.valid && (!cmd.cond_en || cond_true);

  // adder source from input registers; src_other_acc is replaced by the other accumulator in stage 2
  always_comb begin
    nxt_opnd = `ACC_RESET;
    unique case (cmd.src)
      mac_alu_pkg::src_x_high: nxt_opnd = {{8{operand_x_high[23]}}, operand_x_high, 24'h000000};
      mac_alu_pkg::src_x_low:  nxt_opnd = {{8{operand_x_low[23]}}, operand_x_low, 24'h000000};
      mac_alu_pkg::src_y_high: nxt_opnd = {{8{operand_y_high[23]}}, operand_y_high, 24'h000000};
      mac_alu_pkg::src_y_low:  nxt_opnd = {{8{operand_y_low[23]}}, operand_y_low, 24'h000000};
      mac_alu_pkg::src_x:      nxt_opnd = {{8{operand_x_high[23]}}, operand_x_high, operand_x_low};
      mac_alu_pkg::src_y:      nxt_opnd = {{8{operand_y_high[23]}}, operand_y_high, operand_y_low};
      default:                 nxt_opnd = `ACC_RESET;
    endcase
  end

  // a new operation is taken every clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_valid_ff <= 1'b0;
      s1_cmd_ff   <= '0;
      s1_prod_ff  <= `ACC_RESET;
      s1_opnd_ff  <= `ACC_RESET;
    end else begin
      s1_valid_ff <= issue_exec;
      s1_cmd_ff   <= cmd;
      // two multiplier operands, accumulator is the third
      s1_prod_ff  <= f_mul(f_word(in_reg_ff[cmd.mul_a], sixteen_bit_mode),
                           f_word(in_reg_ff[cmd.mul_b], sixteen_bit_mode),
                           cmd.signed_a, cmd.signed_b);
      s1_opnd_ff  <= nxt_opnd;
    end
  end

  // ---------------------------------------------------------------
  // stage 2: accumulate, shift, round
  // ---------------------------------------------------------------
  logic [55:0] dst_val, other_val, src_val, nxt_result;

  // stage 2 reads accumulators written one clock earlier
  assign dst_val   = s1_cmd_ff.dst_b ? acc_b_ff : acc_a_ff;
  assign other_val = s1_cmd_ff.dst_b ? acc_a_ff : acc_b_ff;
  assign src_val   = (s1_cmd_ff.src == mac_alu_pkg::src_other_acc) ? other_val : s1_opnd_ff;

  always_comb begin
    logic [55:0] r;
    r = dst_val;
    unique case (s1_cmd_ff.op)
      mac_alu_pkg::op_mpy: r = s1_prod_ff;
      mac_alu_pkg::op_mac: r = dst_val + s1_prod_ff;
      mac_alu_pkg::op_add: r = dst_val + src_val;
      mac_alu_pkg::op_sub: r = dst_val - src_val;
      mac_alu_pkg::op_tfr: r = src_val;
      mac_alu_pkg::op_and: r = {dst_val[55:48], dst_val[47:24] & src_val[47:24], dst_val[23:0]};
      mac_alu_pkg::op_or:  r = {dst_val[55:48], dst_val[47:24] | src_val[47:24], dst_val[23:0]};
      mac_alu_pkg::op_eor: r = {dst_val[55:48], dst_val[47:24] ^ src_val[47:24], dst_val[23:0]};
      mac_alu_pkg::op_asl, mac_alu_pkg::op_asr, mac_alu_pkg::op_lsr:
        r = f_shift(dst_val, s1_cmd_ff.op, s1_cmd_ff.shift_amt);
      mac_alu_pkg::op_clr: r = `ACC_RESET;
      mac_alu_pkg::op_neg: r = `ACC_RESET - dst_val;
      default:             r = dst_val;
    endcase
    // round lower field into upper, else keep
    if (s1_cmd_ff.round || s1_cmd_ff.op == mac_alu_pkg::op_rnd) begin
      r = (r + `ROUND_CONST) & `ROUND_MASK;
    end
    if (sixteen_bit_mode) begin
      r = r & `ACC16_MASK;
    end
    nxt_result = r;
  end

  // ---------------------------------------------------------------
  // accumulators
  // ---------------------------------------------------------------
  // results land only in an accumulator
  // bus loads override a same-cycle result
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_a_ff <= `ACC_RESET;
    end else if (f_hits_acc(second_memory_data_bus, 1'b0)) begin
      acc_a_ff <= f_acc_load(acc_a_ff, second_memory_data_bus, sixteen_bit_mode, 1'b0);
    end else if (f_hits_acc(first_memory_data_bus, 1'b0)) begin
      acc_a_ff <= f_acc_load(acc_a_ff, first_memory_data_bus, sixteen_bit_mode, 1'b0);
    end else if (s1_valid_ff && !s1_cmd_ff.dst_b) begin
      acc_a_ff <= nxt_result;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_b_ff <= `ACC_RESET;
    end else if (f_hits_acc(second_memory_data_bus, 1'b1)) begin
      acc_b_ff <= f_acc_load(acc_b_ff, second_memory_data_bus, sixteen_bit_mode, 1'b1);
    end else if (f_hits_acc(first_memory_data_bus, 1'b1)) begin
      acc_b_ff <= f_acc_load(acc_b_ff, first_memory_data_bus, sixteen_bit_mode, 1'b1);
    end else if (s1_valid_ff && s1_cmd_ff.dst_b) begin
      acc_b_ff <= nxt_result;
    end
  end

  // status of the last completed operation
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_valid    <= 1'b0;
      result_zero     <= 1'b0;
      result_negative <= 1'b0;
    end else begin
      result_valid <= s1_valid_ff;
      if (s1_valid_ff) begin
        result_zero     <= (nxt_result == `ACC_RESET);
        result_negative <= nxt_result[55];
      end
    end
  end

  // ---------------------------------------------------------------
  // bus read paths
  // ---------------------------------------------------------------
  logic [47:0] lim1_data, lim2_data;
  logic        lim1_flag, lim2_flag;

  bus_limiter u_limiter_first (
    .acc_value    (first_memory_data_bus.sel == mac_alu_pkg::rs_b ? acc_b_ff : acc_a_ff),
    .wide         (first_memory_data_bus.wide),
    .mode16       (sixteen_bit_mode),
    .limited_data (lim1_data),
    .limited      (lim1_flag)
  );

  bus_limiter u_limiter_second (
    .acc_value    (second_memory_data_bus.sel == mac_alu_pkg::rs_b ? acc_b_ff : acc_a_ff),
    .wide         (second_memory_data_bus.wide),
    .mode16       (sixteen_bit_mode),
    .limited_data (lim2_data),
    .limited      (lim2_flag)
  );

  // read mux, narrow reads sit in low bits
  function automatic logic [47:0] f_read(input mac_alu_pkg::bus_req_t r, input logic [47:0] lim);
    unique case (r.sel)
      mac_alu_pkg::rs_x_high: f_read = {24'h000000, operand_x_high};
      mac_alu_pkg::rs_x_low:  f_read = {24'h000000, operand_x_low};
      mac_alu_pkg::rs_y_high: f_read = {24'h000000, operand_y_high};
      mac_alu_pkg::rs_y_low:  f_read = {24'h000000, operand_y_low};
      mac_alu_pkg::rs_a_ext:  f_read = {40'h0, acc_a_ext};
      mac_alu_pkg::rs_a_high: f_read = {24'h000000, acc_a_high};
      mac_alu_pkg::rs_a_low:  f_read = {24'h000000, acc_a_low};
      mac_alu_pkg::rs_b_ext:  f_read = {40'h0, acc_b_ext};
      mac_alu_pkg::rs_b_high: f_read = {24'h000000, acc_b_high};
      mac_alu_pkg::rs_b_low:  f_read = {24'h000000, acc_b_low};
      mac_alu_pkg::rs_x:      f_read = {operand_x_high, operand_x_low};
      mac_alu_pkg::rs_y:      f_read = {operand_y_high, operand_y_low};
      default:                f_read = lim;
    endcase
  endfunction

  function automatic logic f_is_full_acc(input mac_alu_pkg::reg_sel_t s);
    f_is_full_acc = (s == mac_alu_pkg::rs_a) || (s == mac_alu_pkg::rs_b);
  endfunction

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_bus_rdata    <= 48'h0;
      first_bus_limited  <= 1'b0;
      second_bus_rdata   <= 48'h0;
      second_bus_limited <= 1'b0;
    end else begin
      first_bus_limited  <= first_memory_data_bus.rd && f_is_full_acc(first_memory_data_bus.sel)
                            && lim1_flag;
      second_bus_limited <= second_memory_data_bus.rd && f_is_full_acc(second_memory_data_bus.sel)
                            && lim2_flag;
      if (first_memory_data_bus.rd) begin
        first_bus_rdata <= f_read(first_memory_data_bus, lim1_data);
      end
      if (second_memory_data_bus.rd) begin
        second_bus_rdata <= f_read(second_memory_data_bus, lim2_data);
      end
    end
  end

endmodule // fractional_mac_data_alu

// file: sim/mac_alu_monitor.sv
// port checker for the fractional mac data alu
`timescale 1ns/1ns
module mac_alu_monitor (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  sixteen_bit_mode,
  input wire mac_alu_pkg::alu_cmd_t cmd,
  input wire logic                  cond_true,
  input wire mac_alu_pkg::bus_req_t first_memory_data_bus,
  input wire mac_alu_pkg::bus_req_t second_memory_data_bus,
  input wire logic [47:0]           first_bus_rdata,
  input wire logic                  first_bus_limited,
  input wire logic                  second_bus_limited,
  input wire logic                  result_valid,
  input wire logic [55:0]           acc_a,
  input wire logic [55:0]           acc_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_issue;
    cmd.valid && (!cmd.cond_en || cond_true);
  endsequence
  sequence s_done;
    ##2 result_valid;
  endsequence
  a_issue_done: assert property (s_issue |-> s_done)
    else $error("issued op gave no result pulse");
  a_valid_cause: assert property (result_valid |->
    $past(cmd.valid && (!cmd.cond_en || cond_true), 2))
    else $error("result pulse without executed op");
  a_reset_clear: assert property (disable iff (1'b0) !reset_n |=> acc_a == 56'h0
    && acc_b == 56'h0) else $error("accumulators not clear in reset");
  a_lim_first: assert property (first_bus_limited |-> $past(first_memory_data_bus.rd
    && first_memory_data_bus.sel inside {mac_alu_pkg::rs_a, mac_alu_pkg::rs_b}))
    else $error("first bus limited without acc read");
  a_lim_second: assert property (second_bus_limited |-> $past(second_memory_data_bus.rd
    && second_memory_data_bus.sel inside {mac_alu_pkg::rs_a, mac_alu_pkg::rs_b}))
    else $error("second bus limited without acc read");
  a_sat_narrow: assert property (first_bus_limited && !$past(first_memory_data_bus.wide)
    && !$past(sixteen_bit_mode) |-> first_bus_rdata[23:0] inside {24'h7fffff, 24'h800000})
    else $error("saturated narrow read wrong value");
  a_rdata_hold: assert property (!first_memory_data_bus.rd |=> $stable(first_bus_rdata))
    else $error("read data moved without read");
  a_write_acc: assert property (first_memory_data_bus.wr && first_memory_data_bus.wide
    && first_memory_data_bus.sel == mac_alu_pkg::rs_a && !second_memory_data_bus.wr
    && !sixteen_bit_mode |=> acc_a[47:0] == $past(first_memory_data_bus.wdata))
    else $error("wide write did not load acc a");
endmodule // mac_alu_monitor
bind fractional_mac_data_alu mac_alu_monitor mon_i (.clk, .reset_n, .sixteen_bit_mode, .cmd,
  .cond_true, .first_memory_data_bus, .second_memory_data_bus, .first_bus_rdata,
  .first_bus_limited, .second_bus_limited, .result_valid, .acc_a, .acc_b);

// file: sim/core_side_model.sv
// far-side model: operation issue and the two memory data buses
`timescale 1ns/1ns
module core_side_model (
  input  wire logic             clk,
  output mac_alu_pkg::alu_cmd_t cmd,
  output logic                  cond_true,
  output mac_alu_pkg::bus_req_t xbus,
  output mac_alu_pkg::bus_req_t ybus
);
  initial begin
    cmd = '0;
    cond_true = 1'b0;
    xbus = '0;
    ybus = '0;
  end
  task automatic issue(input mac_alu_pkg::alu_cmd_t c, input logic ct);
    @(negedge clk);
    cmd <= c;
    cond_true <= ct;
  endtask
  task automatic bus(input logic second, input mac_alu_pkg::bus_req_t r);
    @(negedge clk);
    if (second) ybus <= r;
    else xbus <= r;
  endtask
  // released buses show inverted data, never stale
  task automatic quiet();
    @(negedge clk);
    cmd <= '0;
    xbus <= '{1'b0, 1'b0, 1'b0, xbus.sel, ~xbus.wdata};
    ybus <= '{1'b0, 1'b0, 1'b0, ybus.sel, ~ybus.wdata};
  endtask
endmodule // core_side_model

// file: sim/tb.sv
// self-checking bench for the fractional mac data alu
`timescale 1ns/1ns
module tb;
  logic                  clk, reset_n, sixteen_bit_mode, cond_true, result_valid;
  logic                  lim1, lim2, res_zero, res_neg;
  mac_alu_pkg::alu_cmd_t cmd;
  mac_alu_pkg::bus_req_t xbus, ybus;
  logic [47:0]           rd1, rd2;
  logic [55:0]           acc_a, acc_b, v;
  logic [56:0]           exp_q[$];
  logic [56:0]           e;
  logic [23:0]           w[4];
  int                    seed = 2, i, err_total = 0, n_compared = 0;
  fractional_mac_data_alu fractional_mac_data_alu_i (.clk, .reset_n, .sixteen_bit_mode,
    .cmd, .cond_true, .first_memory_data_bus(xbus), .second_memory_data_bus(ybus),
    .first_bus_rdata(rd1), .first_bus_limited(lim1), .second_bus_rdata(rd2),
    .second_bus_limited(lim2), .result_valid, .result_zero(res_zero), .result_negative(res_neg),
    .acc_a, .acc_b);
  core_side_model core (.clk, .cmd, .cond_true, .xbus, .ybus);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string what, input logic [55:0] seen, input logic [55:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic mac_alu_pkg::alu_cmd_t mk(input mac_alu_pkg::alu_op_t o,
      input logic [1:0] ma, mb, input logic sa, sb, db, rn, ce);
    return '{1'b1, o, ma, mb, sa, sb, mac_alu_pkg::src_x_high, db, rn, ce, {2'h0, ma, mb}};
  endfunction
  function automatic mac_alu_pkg::bus_req_t br(input logic wr, wd,
      input mac_alu_pkg::reg_sel_t s, input logic [47:0] d);
    return '{wr, !wr, wd, s, d};
  endfunction
  function automatic logic [55:0] prod(input logic [23:0] a, b, input logic sa, sb);
    logic signed [55:0] p;
    p = $signed({sa & a[23], a}) * $signed({sb & b[23], b});
    return p <<< 1;
  endfunction
  task automatic rd(input logic s, wd, input mac_alu_pkg::reg_sel_t r,
      input logic [47:0] ed, input logic el);
    core.bus(s, br(1'b0, wd, r, 48'h0));
    core.quiet();
    check("rdata", s ? rd2 : rd1, ed);
    check("limited", s ? lim2 : lim1, el);
  endtask
  // expected accumulator values checked in issue order
  always @(negedge clk) begin
    if (result_valid === 1'b1) begin
      if (exp_q.size() == 0) check("extra result", 56'h1, 56'h0);
      else begin
        e = exp_q.pop_front();
        check("acc", e[56] ? acc_b : acc_a, e[55:0]);
        check("flags", {res_zero, res_neg}, {e[55:0] == 56'h0, e[55]});
      end
    end
  end
  initial begin
    reset_n = 1'b0;
    sixteen_bit_mode = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    check("acc_b", acc_b, 56'h0);
    for (i = 0; i < 4; i++) w[i] = $random(seed);
    w[0] = w[0] | 24'h800000;
    w[3] = w[3] & 24'h1fffff;
    for (i = 0; i < 4; i++) core.bus(i[0], br(1'b1, 1'b0, mac_alu_pkg::reg_sel_t'(i), 48'(w[i])));
    core.quiet();
    core.issue(mk(mac_alu_pkg::op_mpy, 0, 2, 1, 1, 0, 0, 0), 1'b0);
    v = prod(w[0], w[2], 1, 1);
    exp_q.push_back({1'b0, v});
    core.issue(mk(mac_alu_pkg::op_mac, 1, 3, 1, 1, 0, 0, 0), 1'b0);
    v = v + prod(w[1], w[3], 1, 1);
    exp_q.push_back({1'b0, v});
    core.issue(mk(mac_alu_pkg::op_mpy, 0, 3, 0, 1, 1, 0, 0), 1'b0);
    exp_q.push_back({1'b1, prod(w[0], w[3], 0, 1)});
    core.issue(mk(mac_alu_pkg::op_mpy, 0, 2, 1, 1, 1, 1, 0), 1'b0);
    exp_q.push_back({1'b1, (prod(w[0], w[2], 1, 1) + 56'h800000) & 56'hff_ffffff_000000});
    core.issue(mk(mac_alu_pkg::op_clr, 0, 0, 0, 0, 0, 0, 1), 1'b0);
    core.issue(mk(mac_alu_pkg::op_clr, 0, 0, 0, 0, 1, 0, 1), 1'b1);
    exp_q.push_back({1'b1, 56'h0});
    core.issue(mk(mac_alu_pkg::op_add, 0, 0, 0, 0, 1, 0, 0), 1'b0);
    exp_q.push_back({1'b1, 8'hff, w[0], 24'h0});
    core.issue(mk(mac_alu_pkg::op_asr, 1, 0, 0, 0, 1, 0, 0), 1'b0);
    exp_q.push_back({1'b1, $signed({8'hff, w[0], 24'h0}) >>> 4});
    core.quiet();
    for (i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge clk);
    if (exp_q.size() != 0) err_total++;
    check("acc_a kept", acc_a, v);
    $display("test ops done");
    core.bus(1'b0, br(1'b1, 1'b1, mac_alu_pkg::rs_a, {24'h7fffff, 24'hffffff}));
    core.quiet();
    core.bus(1'b1, br(1'b1, 1'b0, mac_alu_pkg::rs_a_ext, 48'h1));
    core.quiet();
    rd(1'b0, 1'b0, mac_alu_pkg::rs_a, 48'h7fffff, 1'b1);
    rd(1'b1, 1'b1, mac_alu_pkg::rs_a, 48'h7fffff_ffffff, 1'b1);
    core.bus(1'b0, br(1'b1, 1'b0, mac_alu_pkg::rs_b, {24'h0, w[0]}));
    core.quiet();
    rd(1'b0, 1'b0, mac_alu_pkg::rs_b, {24'h0, w[0]}, 1'b0);
    $display("test limiter done");
    sixteen_bit_mode = 1'b1;
    core.bus(1'b1, br(1'b1, 1'b0, mac_alu_pkg::rs_b, {24'h0, w[2]}));
    core.quiet();
    rd(1'b1, 1'b0, mac_alu_pkg::rs_b, {24'h0, w[2] & 24'hffff00}, 1'b0);
    $display("test mode16 done");
    tally_and_finish();
  end
endmodule // tb
